// ### src/abbc_pkg.sv
// Constants shared by the two-wire control register block.
// Assumes a 100 MHz system clock and a 7-bit two-wire slave address.
package abbc_pkg;
    localparam logic [1:0] ABBC_ADDR_TOP    = 2'b11;
    localparam int         ABBC_ADDR_SET_W  = 5;
    // Register 1 field positions
    localparam int         ABBC_R1_LINK     = 7;
    localparam int         ABBC_R1_P2_VAL   = 6;
    localparam int         ABBC_R1_P1_VAL   = 5;
    localparam int         ABBC_R1_P2_LVL   = 4;
    localparam int         ABBC_R1_P1_LVL   = 3;
    // Register 2 field positions
    localparam int         ABBC_R2_P2_DIR   = 7;
    localparam int         ABBC_R2_P1_DIR   = 6;
    localparam int         ABBC_R2_P2_STY   = 5;
    localparam int         ABBC_R2_P1_STY   = 4;
    localparam int         ABBC_R2_CARD_B   = 3;
    localparam int         ABBC_R2_BACK_B   = 2;
    // Reset values of the stored bits, and the fixed read value of register two's low bits
    localparam logic [2:0] ABBC_R1_RST      = 3'h3;
    localparam logic [5:0] ABBC_R2_RST      = 6'h00;
    localparam logic [1:0] ABBC_R2_LOW_ONES = 2'h3;
    // Fastest allowed bus clock, in kHz
    localparam int         ABBC_SCL_MAX_KHZ = 400;
    localparam int         ABBC_CLK_MHZ     = 100;
    // Minimum system clocks per bus clock period
    localparam int         ABBC_SCL_MIN_CYC = (ABBC_CLK_MHZ * 1000) / ABBC_SCL_MAX_KHZ;
    typedef enum logic [2:0] {
        ABBC_IDLE,
        ABBC_ADDR,
        ABBC_WDATA,
        ABBC_RDATA,
        ABBC_RACK,
        ABBC_IGNORE
    } abbc_state_t;
endpackage : abbc_pkg

// ### src/abbc_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk_i; outputs are clk_i-domain levels.
`timescale 1ns/1ps
`default_nettype none
module abbc_sync
    import abbc_pkg::*;
#(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
)(
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_r <= INIT;
            sync_o <= INIT;
        end
        else
        begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule // abbc_sync
`default_nettype wire

// ### src/abbc_ctrl.sv
// Two-wire slave holding the link and pin control registers.
// Assumes SCL and SDA are sampled by clk_i; the bus clock is at most 400 kHz.
//
// Contract
// R1: Master keeps bus clock at most 400kHz
// R2: Acknowledge address 11 plus five-bit setting
// R3: Address bit eight chooses read or write
// R4: Single write byte goes to register one
// R5: Register one bit 7 joins the link
// R6: Bits 6,5 hold pin two/one drive values
// R7: Bits 4,3 read pin two/one levels
// R8: Writes ignore the five read-only bits
// R9: Read returns bits 7..3 then 000
// R10: Register one resets to 011DD000
// R11: Second write byte goes to register two
// R12: Bits 7,6 set pin two/one direction
// R13: Bits 5,4 choose open-drain or push-pull
// R14: Bits 3,2 enable card/backplane boost
// R15: Register two low bits read ones
// R16: Write word: third data byte acknowledged, dropped
// R17: Registers update only on valid Stop
// R18: Start before Stop drops pending bytes
// R19: Master rewrites after an aborted write
// R20: Board seat low restores defaults asynchronously
// R21: Single read returns register one
// R22: Acked first read byte, then register two
// R23: Read word command code is never stored
// R24: Single-pin variant ignores pin two bits
`timescale 1ns/1ps
`default_nettype none
module abbc_ctrl
    import abbc_pkg::*;
#(
    parameter bit SINGLE_PIN = 1'b0
)(
    input  wire logic                       clk_i,
    input  wire logic                       reset_n_i,
    input  wire logic                       board_seat_reset_n_i,
    input  wire logic [ABBC_ADDR_SET_W-1:0] addr_setting_i,
    input  wire logic                       scl_i,
    input  wire logic                       sda_i,
    output logic                            sda_o,
    output logic                            sda_oe_n_o,
    input  wire logic                       port_pin1_i,
    input  wire logic                       port_pin2_i,
    output logic                            port_pin1_o,
    output logic                            port_pin1_oe_n_o,
    output logic                            port_pin2_o,
    output logic                            port_pin2_oe_n_o,
    output logic                            link_join_o,
    output logic                            card_side_boost_en_o,
    output logic                            backplane_boost_en_o
);
    logic [3:0]  sync_w;
    logic        scl_s, sda_s, pin1_s, pin2_s;
    logic        scl_d_r, sda_d_r;
    logic        start_w, stop_w, scl_rise_w, scl_fall_w;
    abbc_state_t state_r;
    logic [7:0]  shift_r;
    logic [3:0]  bit_cnt_r;
    logic        rw_r;
    logic [1:0]  byte_idx_r;
    logic        ack_phase_r;
    logic        drive_low_r;
    logic [2:0]  r1_r;
    logic [5:0]  r2_r;
    logic [2:0]  pend1_r;
    logic [5:0]  pend2_r;
    logic [1:0]  pend_cnt_r;
    logic [7:0]  reg1_view_w;
    logic [7:0]  reg2_view_w;
    logic        rst_all_n_w;

    // Pins cross into the clock domain
    abbc_sync #(
        .WIDTH (4),
        .INIT  (4'hf)
    ) u_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   ({scl_i, sda_i, port_pin1_i, port_pin2_i}),
        .sync_o    (sync_w)
    );
    assign scl_s  = sync_w[3];
    assign sda_s  = sync_w[2];
    assign pin1_s = sync_w[1];
    assign pin2_s = SINGLE_PIN ? 1'b0 : sync_w[0]; // [R24]

    assign rst_all_n_w = reset_n_i & board_seat_reset_n_i; // [R20]

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign start_w    = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_w     = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign scl_rise_w = scl_s & ~scl_d_r;
    assign scl_fall_w = ~scl_s & scl_d_r;

    // Register views
    assign reg1_view_w = {r1_r, pin2_s, pin1_s, 3'h0}; // [R7] [R9] [R10]
    assign reg2_view_w = {r2_r, ABBC_R2_LOW_ONES}; // [R15]

    // Protocol engine
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r     <= ABBC_IDLE;
            shift_r     <= 8'h00;
            bit_cnt_r   <= 4'h0;
            rw_r        <= 1'b0;
            byte_idx_r  <= 2'h0;
            ack_phase_r <= 1'b0;
            drive_low_r <= 1'b0;
            pend1_r     <= 3'h0;
            pend2_r     <= 6'h00;
            pend_cnt_r  <= 2'h0;
        end
        else if (start_w)
        begin
            // Pending write bytes are lost on any start
            state_r     <= ABBC_ADDR; // [R18] [R23]
            bit_cnt_r   <= 4'h0;
            ack_phase_r <= 1'b0;
            drive_low_r <= 1'b0;
            byte_idx_r  <= 2'h0;
            pend_cnt_r  <= 2'h0; // [R18]
        end
        else if (stop_w)
        begin
            state_r     <= ABBC_IDLE;
            drive_low_r <= 1'b0;
            pend_cnt_r  <= 2'h0;
        end
        else
        begin
            case (state_r)
                ABBC_ADDR, ABBC_WDATA:
                begin
                    if (scl_rise_w && !ack_phase_r)
                    begin
                        shift_r   <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else if (scl_fall_w && !ack_phase_r && bit_cnt_r == 4'h8)
                    begin
                        bit_cnt_r <= 4'h0;
                        if (state_r == ABBC_ADDR)
                        begin
                            if (shift_r[7:6] == ABBC_ADDR_TOP
                                && shift_r[5:1] == addr_setting_i) // [R2]
                            begin
                                rw_r        <= shift_r[0]; // [R3]
                                drive_low_r <= 1'b1;
                                ack_phase_r <= 1'b1;
                            end
                            else
                            begin
                                state_r <= ABBC_IGNORE;
                            end
                        end
                        else
                        begin
                            drive_low_r <= 1'b1;
                            ack_phase_r <= 1'b1;
                            if (byte_idx_r == 2'h0)
                            begin
                                pend1_r <= shift_r[7:5]; // [R4] [R8] [R16]
                            end
                            else if (byte_idx_r == 2'h1)
                            begin
                                pend2_r <= shift_r[7:2]; // [R11] [R16]
                            end
                            if (byte_idx_r != 2'h3)
                            begin
                                byte_idx_r <= byte_idx_r + 2'h1;
                            end
                            if (byte_idx_r < 2'h2)
                            begin
                                pend_cnt_r <= byte_idx_r + 2'h1; // [R17]
                            end
                        end
                    end
                    else if (scl_fall_w && ack_phase_r)
                    begin
                        ack_phase_r <= 1'b0;
                        if (state_r == ABBC_ADDR && rw_r)
                        begin
                            state_r     <= ABBC_RDATA;
                            shift_r     <= reg1_view_w; // [R21]
                            drive_low_r <= ~reg1_view_w[7];
                            bit_cnt_r   <= 4'h1;
                        end
                        else
                        begin
                            state_r     <= ABBC_WDATA;
                            drive_low_r <= 1'b0;
                        end
                    end
                end
                ABBC_RDATA:
                begin
                    if (scl_fall_w)
                    begin
                        if (bit_cnt_r == 4'h8)
                        begin
                            drive_low_r <= 1'b0;
                            state_r     <= ABBC_RACK;
                        end
                        else
                        begin
                            shift_r     <= {shift_r[6:0], 1'b0};
                            drive_low_r <= ~shift_r[6];
                            bit_cnt_r   <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                ABBC_RACK:
                begin
                    if (scl_rise_w)
                    begin
                        state_r <= sda_s ? ABBC_IGNORE : ABBC_RACK; // [R22]
                        ack_phase_r <= ~sda_s;
                    end
                    else if (scl_fall_w && ack_phase_r)
                    begin
                        ack_phase_r <= 1'b0;
                        state_r     <= ABBC_RDATA;
                        shift_r     <= reg2_view_w; // [R22]
                        drive_low_r <= ~reg2_view_w[7];
                        bit_cnt_r   <= 4'h1;
                    end
                end
                ABBC_IGNORE, ABBC_IDLE:
                begin
                    drive_low_r <= 1'b0;
                end
                default:
                begin
                    state_r <= ABBC_IDLE;
                end
            endcase
        end
    end

    // Commit pending bytes on a valid stop
    always_ff @(posedge clk_i or negedge rst_all_n_w)
    begin
        if (!rst_all_n_w)
        begin
            r1_r <= ABBC_R1_RST; // [R10] [R20]
            r2_r <= ABBC_R2_RST; // [R15] [R20]
        end
        else if (stop_w && state_r == ABBC_WDATA && !rw_r)
        begin
            if (pend_cnt_r != 2'h0)
            begin
                r1_r[2] <= pend1_r[2]; // [R5] [R17]
                r1_r[0] <= pend1_r[0]; // [R6]
                if (!SINGLE_PIN)
                begin
                    r1_r[1] <= pend1_r[1]; // [R24]
                end
            end
            if (pend_cnt_r == 2'h2)
            begin
                r2_r[4] <= pend2_r[4]; // [R12] [R17]
                r2_r[2] <= pend2_r[2]; // [R13]
                r2_r[1:0] <= pend2_r[1:0]; // [R14]
                if (!SINGLE_PIN)
                begin
                    r2_r[5] <= pend2_r[5]; // [R24]
                    r2_r[3] <= pend2_r[3];
                end
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sda_o                <= 1'b0;
            sda_oe_n_o           <= 1'b1;
            link_join_o          <= 1'b0;
            card_side_boost_en_o <= 1'b0;
            backplane_boost_en_o <= 1'b0;
            port_pin1_o          <= 1'b1;
            port_pin1_oe_n_o     <= 1'b1;
            port_pin2_o          <= 1'b1;
            port_pin2_oe_n_o     <= 1'b1;
        end
        else
        begin
            sda_o                <= 1'b0;
            sda_oe_n_o           <= ~drive_low_r;
            link_join_o          <= r1_r[2]; // [R5]
            card_side_boost_en_o <= r2_r[1]; // [R14]
            backplane_boost_en_o <= r2_r[0]; // [R14]
            // Output when direction bit clear; push-pull drives both levels
            port_pin1_o      <= r1_r[0]; // [R6]
            port_pin1_oe_n_o <= r2_r[4] | (~r2_r[2] & r1_r[0]); // [R12] [R13]
            port_pin2_o      <= r1_r[1];
            port_pin2_oe_n_o <= SINGLE_PIN | r2_r[5] | (~r2_r[3] & r1_r[1]); // [R24]
        end
    end
endmodule // abbc_ctrl
`default_nettype wire

// ### sim/abbc_ctrl_assertions.sv
// Port-level checks for the two-wire control register block.
// Assumes it is bound to abbc_ctrl with the same SINGLE_PIN value.
`timescale 1ns/1ps
`default_nettype none
module abbc_ctrl_assertions
    import abbc_pkg::*;
#(
    parameter bit SINGLE_PIN = 1'b0
)(
    input wire logic                       clk_i,
    input wire logic                       reset_n_i,
    input wire logic                       board_seat_reset_n_i,
    input wire logic [ABBC_ADDR_SET_W-1:0] addr_setting_i,
    input wire logic                       scl_i,
    input wire logic                       sda_i,
    input wire logic                       sda_o,
    input wire logic                       sda_oe_n_o,
    input wire logic                       port_pin1_i,
    input wire logic                       port_pin2_i,
    input wire logic                       port_pin1_o,
    input wire logic                       port_pin1_oe_n_o,
    input wire logic                       port_pin2_o,
    input wire logic                       port_pin2_oe_n_o,
    input wire logic                       link_join_o,
    input wire logic                       card_side_boost_en_o,
    input wire logic                       backplane_boost_en_o
);
    logic       sda_q;
    logic [3:0] since_stop;
    wire logic [6:0] regs_w = {link_join_o, card_side_boost_en_o, backplane_boost_en_o,
                               port_pin1_o, port_pin2_o, port_pin1_oe_n_o, port_pin2_oe_n_o};
    // Cycles since the last stop seen on the raw pins, saturating
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sda_q      <= 1'b1;
            since_stop <= 4'hf;
        end
        else
        begin
            sda_q      <= sda_i;
            if (scl_i && sda_i && !sda_q)
                since_stop <= 4'h0;
            else if (since_stop != 4'hf)
                since_stop <= since_stop + 4'h1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence bus_start_s;
        scl_i && $fell(sda_i);
    endsequence
    sequence seat_release_s;
        !board_seat_reset_n_i ##1 board_seat_reset_n_i;
    endsequence
    seat_clears_regs_a: assert property (!board_seat_reset_n_i |=> regs_w == 7'h0f)
        else $error("board seat reset did not restore defaults");
    seat_release_hold_a: assert property (seat_release_s |-> regs_w == 7'h0f)
        else $error("defaults lost on board seat release");
    ack_scl_low_a: assert property ($changed(sda_oe_n_o) |-> !scl_i)
        else $error("data drive changed while bus clock high");
    sda_low_only_a: assert property (!sda_oe_n_o |-> !sda_o)
        else $error("data line driven high");
    update_at_stop_a: assert property ($changed(regs_w) && board_seat_reset_n_i
        && $past(board_seat_reset_n_i) |-> since_stop < 4'hc)
        else $error("register outputs changed away from a stop");
    start_keeps_regs_a: assert property (bus_start_s |=> $stable(regs_w) [*6])
        else $error("register outputs changed at a start");
    start_sda_free_a: assert property (bus_start_s |-> $past(sda_oe_n_o))
        else $error("data line held at a start");
    seat_pins_idle_a: assert property (!board_seat_reset_n_i |=> regs_w[3:0] == 4'hf)
        else $error("pins not released by board seat reset");
    pin2_single_off_a: assert property (SINGLE_PIN |-> port_pin2_oe_n_o)
        else $error("second pin driven on single-pin variant");
endmodule // abbc_ctrl_assertions
`default_nettype wire

// ### sim/abbc_master_model.sv
// Backplane two-wire bus master driving the control block.
// Assumes a 100 MHz clk_i and the resolved, pulled-up data wire on sda_i.
`timescale 1ns/1ps
`default_nettype none
module abbc_master_model
(
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_o
);
    localparam int Q = 63; // Bus period of 4*Q clocks stays under 400 kHz
    initial scl_o = 1'b1;
    initial sda_o = 1'b1;
    task automatic wait_q();
        repeat (Q) @(negedge clk_i);
    endtask
    task automatic bit_cycle(input logic b, output logic s);
        sda_o = b;
        wait_q();
        scl_o = 1'b1;
        wait_q();
        s = sda_i;
        wait_q();
        scl_o = 1'b0;
        wait_q();
    endtask
    // Start or repeated start
    task automatic bus_start();
        sda_o = 1'b1;
        wait_q();
        scl_o = 1'b1;
        wait_q();
        sda_o = 1'b0;
        wait_q();
        scl_o = 1'b0;
        wait_q();
    endtask
    // A write only counts once closed by a stop
    task automatic bus_stop();
        sda_o = 1'b0;
        wait_q();
        scl_o = 1'b1;
        wait_q();
        sda_o = 1'b1;
        wait_q();
    endtask
    // Address bit eight picks write or read
    task automatic put_byte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(b[i], s);
        bit_cycle(1'b1, ack_n);
    endtask
    // Final read byte gets a not-acknowledge
    task automatic get_byte(input logic ack_n, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(1'b1, b[i]);
        bit_cycle(ack_n, s);
    endtask
endmodule // abbc_master_model
`default_nettype wire

// ### sim/addressable_bus_buffer_ctrl_regs_tb.sv
// Self-checking bench for the two-wire control register block.
// Assumes abbc_ctrl, its checker and the master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module addressable_bus_buffer_ctrl_regs_tb;
    import abbc_pkg::*;
    localparam logic [4:0] ASET = 5'h15;
    // Second device on the same bus, built as the single-pin variant
    localparam logic [4:0] ASET2 = 5'h0a;
    logic [4:0] tgt = ASET;
    logic       clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       seat_n = 1'b1;
    logic       p1_ext = 1'b1;
    logic       p2_ext = 1'b0;
    logic       sda_d, sda_oe_n, p1_o, p1_oe_n, p2_o, p2_oe_n, link, cb, bb;
    logic       scl, m_sda;
    logic       sda_d2, sda_oe_n2, q1_o, q1_oe_n, q2_o, q2_oe_n, link2, cb2, bb2;
    logic [7:0] r0, r1;
    int         err_total = 0;
    int         tests_run = 0;
    int         cycles = 0;
    wire logic  sda_w = m_sda & (sda_oe_n | sda_d) & (sda_oe_n2 | sda_d2);
    wire logic  pin1_w = p1_oe_n ? p1_ext : p1_o;
    wire logic  pin2_w = p2_oe_n ? p2_ext : p2_o;
    always #5 clk_i = ~clk_i;
    abbc_ctrl dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .board_seat_reset_n_i(seat_n),
        .addr_setting_i(ASET), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d), .sda_oe_n_o(sda_oe_n),
        .port_pin1_i(pin1_w), .port_pin2_i(pin2_w), .port_pin1_o(p1_o),
        .port_pin1_oe_n_o(p1_oe_n), .port_pin2_o(p2_o), .port_pin2_oe_n_o(p2_oe_n),
        .link_join_o(link), .card_side_boost_en_o(cb), .backplane_boost_en_o(bb));
    abbc_master_model m_u (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
    abbc_ctrl #(.SINGLE_PIN(1'b1)) dut_single_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .board_seat_reset_n_i(seat_n), .addr_setting_i(ASET2), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_d2), .sda_oe_n_o(sda_oe_n2), .port_pin1_i(q1_oe_n ? p1_ext : q1_o),
        .port_pin2_i(p1_ext), .port_pin1_o(q1_o), .port_pin1_oe_n_o(q1_oe_n),
        .port_pin2_o(q2_o), .port_pin2_oe_n_o(q2_oe_n), .link_join_o(link2),
        .card_side_boost_en_o(cb2), .backplane_boost_en_o(bb2));
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic settle();
        repeat (10) @(negedge clk_i);
    endtask
    task automatic send(input int n, input logic [23:0] d, input logic fin);
        logic a;
        m_u.bus_start();
        m_u.put_byte({2'b11, tgt, 1'b0}, a);
        check({7'h00, a}, 8'h00, "write address ack");
        for (int i = 0; i < n; i++)
        begin
            m_u.put_byte(d[23-8*i -: 8], a);
            check({7'h00, a}, 8'h00, "write data ack");
        end
        if (fin)
            m_u.bus_stop();
        settle();
    endtask
    task automatic fetch(input logic two);
        logic a;
        m_u.bus_start();
        m_u.put_byte({2'b11, tgt, 1'b1}, a);
        check({7'h00, a}, 8'h00, "read address ack");
        m_u.get_byte(!two, r0);
        if (two)
            m_u.get_byte(1'b1, r1);
        m_u.bus_stop();
        settle();
    endtask
    task automatic s_defaults();
        fetch(1'b1);
        check(r0, 8'h68, "reg1 default");
        check(r1, 8'h03, "reg2 default");
        check({5'h00, link, cb, bb}, 8'h00, "outputs default");
    endtask
    task automatic s_addr_filter();
        logic a;
        m_u.bus_start();
        m_u.put_byte({2'b11, ASET ^ 5'h01, 1'b0}, a);
        check({7'h00, a}, 8'h01, "wrong setting");
        m_u.bus_start();
        m_u.put_byte({2'b10, ASET, 1'b0}, a);
        check({7'h00, a}, 8'h01, "wrong top bits");
        m_u.bus_stop();
        settle();
    endtask
    task automatic s_write_one();
        send(1, 24'h9f0000, 1'b0);
        check({7'h00, link}, 8'h00, "held before stop");
        m_u.bus_stop();
        settle();
        check({4'h0, link, p2_o, p1_o, p1_oe_n}, 8'h08, "link and values");
        fetch(1'b0);
        check(r0, 8'h80, "single read");
    endtask
    task automatic s_write_two();
        send(2, 24'h603c00, 1'b1);
        check({4'h0, cb, bb, p2_oe_n, p1_oe_n}, 8'h0c, "boost and drive");
        fetch(1'b1);
        check(r0, 8'h78, "reg1 two bytes");
        check(r1, 8'h3f, "reg2 two bytes");
    endtask
    task automatic s_write_word();
        send(3, 24'h20c4ff, 1'b1);
        check({4'h0, cb, bb, p2_oe_n, p1_oe_n}, 8'h07, "inputs and boost");
        fetch(1'b1);
        check(r0, 8'h28, "reg1 word");
        check(r1, 8'hc7, "reg2 word");
    endtask
    task automatic s_abort_read_word();
        send(1, 24'h800000, 1'b0);
        fetch(1'b1);
        check(r0, 8'h28, "reg1 after abort");
        check(r1, 8'hc7, "reg2 after abort");
        check({7'h00, link}, 8'h00, "link after abort");
    endtask
    task automatic s_single_pin();
        tgt = ASET2;
        send(2, 24'h80fc00, 1'b1);
        check({1'b0, link2, q2_o, q1_o, q2_oe_n, q1_oe_n, cb2, bb2}, 8'h6f,
            "one-pin outputs");
        fetch(1'b1);
        tgt = ASET;
        check(r0, 8'hc8, "one-pin reg1");
        check(r1, 8'h5f, "one-pin reg2");
    endtask
    task automatic s_seat_reset();
        seat_n = 1'b0;
        repeat (3) @(negedge clk_i);
        check({5'h00, link, cb, bb}, 8'h00, "seat low outputs");
        seat_n = 1'b1;
        settle();
        fetch(1'b1);
        check(r0, 8'h68, "reg1 after seat");
        check(r1, 8'h03, "reg2 after seat");
    endtask
    initial
    begin
        repeat (3) @(negedge clk_i);
        reset_n_i = 1'b1;
        settle();
        s_defaults();
        s_addr_filter();
        s_write_one();
        s_write_two();
        s_write_word();
        s_abort_read_word();
        s_single_pin();
        s_seat_reset();
        complete_run();
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 96000)
        begin
            err_total++;
            complete_run();
        end
    end
endmodule // addressable_bus_buffer_ctrl_regs_tb
bind abbc_ctrl abbc_ctrl_assertions #(.SINGLE_PIN(SINGLE_PIN)) chk_u (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .board_seat_reset_n_i(board_seat_reset_n_i),
    .addr_setting_i(addr_setting_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .port_pin1_i(port_pin1_i), .port_pin2_i(port_pin2_i),
    .port_pin1_o(port_pin1_o), .port_pin1_oe_n_o(port_pin1_oe_n_o),
    .port_pin2_o(port_pin2_o), .port_pin2_oe_n_o(port_pin2_oe_n_o),
    .link_join_o(link_join_o), .card_side_boost_en_o(card_side_boost_en_o),
    .backplane_boost_en_o(backplane_boost_en_o));
`default_nettype wire
